// ==== design/aprs_pkg.sv ====
// Purpose: Shared constants for the acyclic parameter record server and its controller end
// Assumes: Byte-wide record transfer over the carrier interface, one byte per valid cycle
// Notes:   Field positions are byte offsets within the request and response records
package aprs_pkg;
    // ========================================================================
    // Record addressing
    localparam logic [15:0] REC_INDEX        = 16'h002F;   // parameter_record_set index
    localparam logic [7:0]  REQ_KIND_VENDOR  = 8'h40;      // request_kind_byte, vendor service
    localparam logic [7:0]  RSP_KIND_POS     = 8'h40;
    localparam logic [7:0]  RSP_KIND_NEG     = 8'hC0;
    localparam logic [7:0]  AXIS_SELF        = 8'h00;
    localparam logic [7:0]  ELEM_DIRECT      = 8'h00;
    localparam logic [3:0]  SVC_READ         = 4'h1;       // Upper nibble of attribute byte
    localparam logic [7:0]  FMT_DWORD        = 8'h43;
    localparam logic [7:0]  FMT_ERROR        = 8'h44;
    localparam logic [7:0]  RD_MAX_LEN       = 8'hF0;      // Controller response buffer size
    localparam logic [7:0]  REQ_LEN          = 8'h0A;
    localparam logic [7:0]  RSP_LEN_POS      = 8'h0A;
    localparam logic [7:0]  RSP_LEN_NEG      = 8'h08;
    // ========================================================================
    // Request byte positions
    localparam logic [3:0]  B_REF     = 4'h0;
    localparam logic [3:0]  B_KIND    = 4'h1;
    localparam logic [3:0]  B_AXIS    = 4'h2;
    localparam logic [3:0]  B_NPAR    = 4'h3;
    localparam logic [3:0]  B_ATTR    = 4'h4;
    localparam logic [3:0]  B_NELEM   = 4'h5;
    localparam logic [3:0]  B_PNUM_H  = 4'h6;
    localparam logic [3:0]  B_PNUM_L  = 4'h7;
    // ========================================================================
    // Error values for negative responses
    localparam logic [15:0] ERR_BAD_KIND  = 16'h0001;
    localparam logic [15:0] ERR_BAD_SVC   = 16'h0002;
    localparam logic [15:0] ERR_BAD_ELEM  = 16'h0003;
    localparam logic [15:0] ERR_ACCESS    = 16'h0004;
    // ========================================================================
    // Timing: internal processing latency of the own-parameter store
    localparam int          PROC_CYCLES   = 4;
endpackage

// ==== design/aprs_if.sv ====
// Purpose: Carrier for record write/read traffic between controller and device
// Assumes: One clock; byte streams ended by last, valid/ready handshake
// Notes:   Drive path is a separate user port of the device, not part of this carrier
`timescale 1ns/1ps
`default_nettype none
interface aprs_if;
    // Record request header from controller
    logic        req_valid;   // Header valid
    logic        req_ready;   // Header accepted
    logic        req_write;   // 1 = write record, 0 = read record
    logic [15:0] req_index;   // Record index
    logic [7:0]  req_slot;    // Slot number, not evaluated
    logic [7:0]  req_len;     // Write length or read buffer size
    // Write data stream controller -> device
    logic        wr_valid;
    logic        wr_ready;
    logic [7:0]  wr_data;
    logic        wr_last;
    // Read data stream device -> controller
    logic        rd_valid;
    logic        rd_ready;
    logic [7:0]  rd_data;
    logic        rd_last;
    logic        rd_error;    // Request refused (wrong index, no pending response)
    modport ctrl (output req_valid, req_write, req_index, req_slot, req_len,
                  output wr_valid, wr_data, wr_last, rd_ready,
                  input  req_ready, wr_ready, rd_valid, rd_data, rd_last, rd_error);
    modport dev  (input  req_valid, req_write, req_index, req_slot, req_len,
                  input  wr_valid, wr_data, wr_last, rd_ready,
                  output req_ready, wr_ready, rd_valid, rd_data, rd_last, rd_error);
endinterface
`default_nettype wire

// ==== design/aprs_device.sv ====
// Purpose: Device end: decodes parameter record requests and serves responses
// Assumes: Controller writes a request before reading (rule 14); own store is a small array
// Notes:   Drive accesses (axis != 0) go out on a simple request/answer user port
// Overview of operation
// - Stall read response until processing finishes
// - Axis byte selects target drive
// - Axis zero targets own parameters
// - Request kind 0x40 selects vendor service
// - Attribute upper nibble is service code
// - Requests and reads use record index 47
// - Slot number is ignored
// - Reference byte mirrored into response byte 0
// - Axis mirrored into response byte 2
// - Element count zero means direct value
// - Positive read carries format 0x43, count
// - Value sent high word then low word
// - Controller read states buffer size 240
// - Controller writes request, then reads response
// - Failure answers 0xC0, format 0x44, error
`timescale 1ns/1ps
`default_nettype none
module aprs_device #(
    parameter int PNUM_W = 4                 // Own parameter store address bits
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    aprs_if.dev              bus,
    output logic             drv_req,        // Pulse: access for a downstream drive
    output logic [7:0]       drv_axis,
    output logic [3:0]       drv_svc,
    output logic [15:0]      drv_pnum,
    input  wire logic        drv_done,       // Pulse: drive answer ready
    input  wire logic        drv_err,
    input  wire logic [31:0] drv_value
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_WDATA = 3'b001, ST_PROC = 3'b010,
        ST_DRV  = 3'b011, ST_READY = 3'b100, ST_SEND = 3'b101
    } aprs_state_e;

    // Own parameter store, read-only constant values, not touched by reset
    logic [31:0] own_mem [0:(1<<PNUM_W)-1];
    logic [7:0]  req_reg [0:9];
    logic [7:0]  req_next [0:9];
    aprs_state_e st_reg, st_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [2:0]  pc_reg, pc_next;
    logic        neg_reg, neg_next;
    logic [15:0] err_reg, err_next;
    logic [31:0] val_reg, val_next;
    logic        hdr_ok;

    // Response byte at position p
    function automatic logic [7:0] rsp_byte(input logic [3:0] p, input logic neg,
                                           input logic [7:0] r0, input logic [7:0] r2,
                                           input logic [31:0] v, input logic [15:0] e);
        case (p)
            4'h0:    rsp_byte = r0;
            4'h1:    rsp_byte = neg ? aprs_pkg::RSP_KIND_NEG
                                    : aprs_pkg::RSP_KIND_POS;
            4'h2:    rsp_byte = r2;
            4'h3:    rsp_byte = 8'h01;
            4'h4:    rsp_byte = neg ? aprs_pkg::FMT_ERROR
                                    : aprs_pkg::FMT_DWORD;
            4'h5:    rsp_byte = 8'h01;
            4'h6:    rsp_byte = neg ? e[15:8] : v[31:24];
            4'h7:    rsp_byte = neg ? e[7:0]  : v[23:16];
            4'h8:    rsp_byte = v[15:8];
            4'h9:    rsp_byte = v[7:0];
            default: rsp_byte = 8'h00;
        endcase
    endfunction

    // Own store contents: firmware-like pattern, constant
    genvar gi;
    generate
        for (gi = 0; gi < (1<<PNUM_W); gi++) begin : g_own
            assign own_mem[gi] = {16'h0000, 16'(gi)};
        end
    endgenerate

    // Index check only; slot number deliberately unused
    assign hdr_ok = (bus.req_index == aprs_pkg::REC_INDEX);

    // Handshake outputs
    always_comb begin
        bus.req_ready = 1'b0;
        bus.rd_error  = 1'b0;
        if (bus.req_valid) begin
            if (bus.req_write) begin
                bus.req_ready = (st_reg == ST_IDLE);
                bus.rd_error  = (st_reg == ST_IDLE) && !hdr_ok;
            end else begin
                // Read held off while processing is running
                bus.req_ready = (st_reg != ST_WDATA) && (st_reg != ST_PROC)
                             && (st_reg != ST_DRV) && (st_reg != ST_SEND);
                bus.rd_error  = bus.req_ready && (!hdr_ok || st_reg != ST_READY);
            end
        end
    end
    assign bus.wr_ready = (st_reg == ST_WDATA);
    assign bus.rd_valid = (st_reg == ST_SEND);
    assign bus.rd_data  = rsp_byte(cnt_reg, neg_reg, req_reg[0], req_reg[2], val_reg, err_reg);
    assign bus.rd_last  = (st_reg == ST_SEND) &&
                          (cnt_reg == (neg_reg ? 4'h7 : 4'h9));
    assign drv_req  = (st_reg == ST_PROC) && (pc_reg == 3'h0) && (req_reg[2] != aprs_pkg::AXIS_SELF)
                      && !neg_reg;
    assign drv_axis = req_reg[aprs_pkg::B_AXIS];
    assign drv_svc  = req_reg[aprs_pkg::B_ATTR][7:4];
    assign drv_pnum = {req_reg[aprs_pkg::B_PNUM_H], req_reg[aprs_pkg::B_PNUM_L]};

    // Sequencer next state
    always_comb begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        pc_next  = pc_reg;
        neg_next = neg_reg;
        err_next = err_reg;
        val_next = val_reg;
        for (int i = 0; i < 10; i++) begin
            req_next[i] = req_reg[i];
        end
        case (st_reg)
            ST_IDLE, ST_READY: begin
                if (bus.req_valid && bus.req_ready && !bus.rd_error) begin
                    if (bus.req_write) begin
                        st_next  = ST_WDATA;
                        cnt_next = 4'h0;
                    end else begin
                        st_next  = ST_SEND;
                        cnt_next = 4'h0;
                    end
                end
            end
            ST_WDATA: begin
                if (bus.wr_valid) begin
                    if (cnt_reg < 4'hA) begin
                        req_next[cnt_reg] = bus.wr_data;
                    end
                    cnt_next = cnt_reg + 4'h1;
                    if (bus.wr_last) begin
                        st_next = ST_PROC;
                        pc_next = 3'h0;
                        neg_next = 1'b0;
                        err_next = 16'h0000;
                    end
                end
            end
            ST_PROC: begin
                // Decode on the first processing cycle
                if (pc_reg == 3'h0) begin
                    if (req_reg[aprs_pkg::B_KIND] != aprs_pkg::REQ_KIND_VENDOR) begin
                        neg_next = 1'b1;
                        err_next = aprs_pkg::ERR_BAD_KIND;
                        st_next  = ST_READY;
                    end else if (req_reg[aprs_pkg::B_ATTR][7:4] != aprs_pkg::SVC_READ) begin
                        neg_next = 1'b1;
                        err_next = aprs_pkg::ERR_BAD_SVC;
                        st_next  = ST_READY;
                    end else if (req_reg[aprs_pkg::B_NELEM] != aprs_pkg::ELEM_DIRECT) begin
                        neg_next = 1'b1;
                        err_next = aprs_pkg::ERR_BAD_ELEM;
                        st_next  = ST_READY;
                    end else if (req_reg[aprs_pkg::B_AXIS] != aprs_pkg::AXIS_SELF) begin
                        st_next = ST_DRV;
                    end
                end
                // Own parameter access after fixed latency
                if (pc_reg == 3'(aprs_pkg::PROC_CYCLES - 1)) begin
                    val_next = own_mem[req_reg[aprs_pkg::B_PNUM_L][PNUM_W-1:0]];
                    if (req_reg[aprs_pkg::B_PNUM_H] != 8'h00 ||
                        req_reg[aprs_pkg::B_PNUM_L][7:PNUM_W] != '0) begin
                        neg_next = 1'b1;
                        err_next = aprs_pkg::ERR_ACCESS;
                    end
                    st_next = ST_READY;
                end
                pc_next = pc_reg + 3'h1;
            end
            ST_DRV: begin
                if (drv_done) begin
                    val_next = drv_value;
                    neg_next = drv_err;
                    err_next = drv_err ? aprs_pkg::ERR_ACCESS : 16'h0000;
                    st_next  = ST_READY;
                end
            end
            ST_SEND: begin
                if (bus.rd_ready) begin
                    cnt_next = cnt_reg + 4'h1;
                    if (bus.rd_last) begin
                        st_next = ST_IDLE;
                    end
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg  <= ST_IDLE;
            cnt_reg <= 4'h0;
            pc_reg  <= 3'h0;
            neg_reg <= 1'b0;
            err_reg <= 16'h0000;
            val_reg <= 32'h0000_0000;
            for (int i = 0; i < 10; i++) begin
                req_reg[i] <= 8'h00;
            end
        end else begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
            pc_reg  <= pc_next;
            neg_reg <= neg_next;
            err_reg <= err_next;
            val_reg <= val_next;
            for (int i = 0; i < 10; i++) begin
                req_reg[i] <= req_next[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/aprs_ctrl.sv ====
// Purpose: Controller end: writes a parameter read request then collects the response
// Assumes: User pulses start with the request fields held stable until done
// Notes:   Read is retried automatically while the device holds it off
`timescale 1ns/1ps
`default_nettype none
module aprs_ctrl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    aprs_if.ctrl             bus,
    input  wire logic        start,          // Pulse: begin a transaction
    input  wire logic [7:0]  ref_in,
    input  wire logic [7:0]  axis_in,
    input  wire logic [7:0]  attr_in,
    input  wire logic [15:0] pnum_in,
    output logic             done,           // Pulse: response collected
    output logic             busy,
    output logic             neg,            // Negative response seen
    output logic [7:0]       rsp_ref,
    output logic [7:0]       rsp_axis,
    output logic [31:0]      rsp_value
);
    typedef enum logic [2:0] {
        CS_IDLE = 3'b000, CS_WHDR = 3'b001, CS_WDAT = 3'b010,
        CS_RHDR = 3'b011, CS_RDAT = 3'b100, CS_DONE = 3'b101
    } aprs_cstate_e;

    aprs_cstate_e st_reg, st_next;
    logic [3:0]   cnt_reg, cnt_next;
    logic [7:0]   b_reg [0:9];
    logic [7:0]   b_next [0:9];
    logic [7:0]   wbyte;

    // Request byte image
    always_comb begin
        case (cnt_reg)
            4'h0:    wbyte = ref_in;
            4'h1:    wbyte = aprs_pkg::REQ_KIND_VENDOR;
            4'h2:    wbyte = axis_in;
            4'h3:    wbyte = 8'h01;
            4'h4:    wbyte = attr_in;
            4'h5:    wbyte = aprs_pkg::ELEM_DIRECT;
            4'h6:    wbyte = pnum_in[15:8];
            4'h7:    wbyte = pnum_in[7:0];
            default: wbyte = 8'h00;
        endcase
    end

    // Bus outputs, write before read
    assign bus.req_valid = (st_reg == CS_WHDR) || (st_reg == CS_RHDR);
    assign bus.req_write = (st_reg == CS_WHDR);
    assign bus.req_index = aprs_pkg::REC_INDEX;
    assign bus.req_slot  = 8'h00;
    assign bus.req_len   = (st_reg == CS_WHDR) ? aprs_pkg::REQ_LEN
                                              : aprs_pkg::RD_MAX_LEN;
    assign bus.wr_valid  = (st_reg == CS_WDAT);
    assign bus.wr_data   = wbyte;
    assign bus.wr_last   = (st_reg == CS_WDAT) && (cnt_reg == 4'h9);
    assign bus.rd_ready  = (st_reg == CS_RDAT);
    assign busy          = (st_reg != CS_IDLE);
    assign done          = (st_reg == CS_DONE);
    assign neg           = (b_reg[1] == aprs_pkg::RSP_KIND_NEG);
    assign rsp_ref       = b_reg[0];
    assign rsp_axis      = b_reg[2];
    assign rsp_value     = {b_reg[6], b_reg[7], b_reg[8], b_reg[9]};

    // Sequence next state
    always_comb begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        for (int i = 0; i < 10; i++) begin
            b_next[i] = b_reg[i];
        end
        case (st_reg)
            CS_IDLE: if (start) st_next = CS_WHDR;
            CS_WHDR: begin
                if (bus.req_ready) begin
                    st_next  = bus.rd_error ? CS_IDLE : CS_WDAT;
                    cnt_next = 4'h0;
                end
            end
            CS_WDAT: begin
                if (bus.wr_ready) begin
                    cnt_next = cnt_reg + 4'h1;
                    if (bus.wr_last) st_next = CS_RHDR;
                end
            end
            CS_RHDR: begin
                // A refused read is simply reissued
                if (bus.req_ready && !bus.rd_error) begin
                    st_next  = CS_RDAT;
                    cnt_next = 4'h0;
                end
            end
            CS_RDAT: begin
                if (bus.rd_valid) begin
                    b_next[cnt_reg] = bus.rd_data;
                    cnt_next = cnt_reg + 4'h1;
                    if (bus.rd_last) st_next = CS_DONE;
                end
            end
            CS_DONE: st_next = CS_IDLE;
            default: st_next = CS_IDLE;
        endcase
    end

    // Sequence registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg  <= CS_IDLE;
            cnt_reg <= 4'h0;
            for (int i = 0; i < 10; i++) begin
                b_reg[i] <= 8'h00;
            end
        end else begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
            for (int i = 0; i < 10; i++) begin
                b_reg[i] <= b_next[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/aprs_checker.sv ====
// Purpose: Assertions on the record link between controller and device ends
// Assumes: One clock, synchronous active-low reset
// Notes:   Takes the carrier signals as plain inputs
`timescale 1ns/1ps
`default_nettype none
module aprs_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic [15:0] req_index,
    input wire logic [7:0]  req_len,
    input wire logic        wr_valid,
    input wire logic        wr_ready,
    input wire logic        wr_last,
    input wire logic        rd_valid,
    input wire logic        rd_ready,
    input wire logic [7:0]  rd_data,
    input wire logic        rd_last,
    input wire logic        rd_error
);
    // ========================================================================
    // Response byte position and captured response kind
    logic [3:0] rd_cnt;
    logic [7:0] kind_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_cnt <= 4'h0;
            kind_r <= 8'h00;
        end else if (rd_valid && rd_ready) begin
            rd_cnt <= rd_last ? 4'h0 : rd_cnt + 4'h1;
            if (rd_cnt == 4'h1) kind_r <= rd_data;
        end
    end
    // ========================================================================
    // Link properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    proc_hold_a: assert property (
        wr_valid && wr_ready && wr_last |=> req_valid && !req_write && !req_ready)
        else $error("read header not held off while the request is processed");
    idx_refuse_a: assert property (
        req_valid && req_ready && req_write |-> rd_error == (req_index != aprs_pkg::REC_INDEX))
        else $error("write header refusal does not follow the record index");
    idx_rd_refuse_a: assert property (
        req_valid && req_ready && req_index != aprs_pkg::REC_INDEX |-> rd_error)
        else $error("header with a wrong record index was not refused");
    rd_len_a: assert property (
        req_valid && !req_write |-> req_len == aprs_pkg::RD_MAX_LEN)
        else $error("read header length is not the buffer size");
    wr_hdr_a: assert property (
        req_valid && req_write |-> req_len == aprs_pkg::REQ_LEN && req_index == aprs_pkg::REC_INDEX)
        else $error("write header length or index wrong");
    rd_start_a: assert property (
        req_valid && req_ready && !req_write && !rd_error |=> rd_valid)
        else $error("response did not start after read header");
    rsp_kind_a: assert property (
        rd_valid && rd_cnt == 4'h1 |-> rd_data == aprs_pkg::RSP_KIND_POS
                                       || rd_data == aprs_pkg::RSP_KIND_NEG)
        else $error("response kind byte invalid");
    rsp_fmt_a: assert property (
        rd_valid && rd_cnt == 4'h4 |-> rd_data == ((kind_r == aprs_pkg::RSP_KIND_POS)
                                       ? aprs_pkg::FMT_DWORD : aprs_pkg::FMT_ERROR))
        else $error("format byte does not match response kind");
    rsp_last_a: assert property (
        rd_valid && rd_last |-> rd_cnt == ((kind_r == aprs_pkg::RSP_KIND_POS) ? 4'h9 : 4'h7))
        else $error("response length wrong for its kind");
endmodule
`default_nettype wire

// ==== test/acyclic_param_record_server_test.sv ====
// Purpose: Self-checking bench joining controller and device ends over one link
// Assumes: Inputs change on the falling edge; drive answers come from a bench responder
// Notes:   Link bytes are captured on the wire and compared with images built here
`timescale 1ns/1ps
`default_nettype none
module acyclic_param_record_server_test;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        start = 1'h0;
    logic [7:0]  ref_in = 8'h00, axis_in = 8'h00, attr_in = 8'h00, d_axis;
    logic [15:0] pnum_in = 16'h0000, d_pnum, drv_pnum;
    logic        done, neg, busy, drv_req, drv_done = 1'h0, drv_err = 1'h0, drv_fail = 1'h0;
    logic [7:0]  rsp_ref, rsp_axis, drv_axis;
    logic [31:0] rsp_value, drv_value = 32'h00000000;
    logic [3:0]  drv_svc, d_svc;
    logic [7:0]  q1[$], w1[$];
    int          drv_hits = 0, n_mismatch = 0, check_count = 0;
    aprs_if link_if ();
    // ========================================================================
    // Both ends and the checker on one link
    aprs_device aprs_device_i (.clk(clk), .rst_n(rst_n), .bus(link_if.dev), .drv_req(drv_req),
        .drv_axis(drv_axis), .drv_svc(drv_svc), .drv_pnum(drv_pnum), .drv_done(drv_done),
        .drv_err(drv_err), .drv_value(drv_value));
    aprs_ctrl aprs_ctrl_i (.clk(clk), .rst_n(rst_n), .bus(link_if.ctrl), .start(start),
        .ref_in(ref_in), .axis_in(axis_in), .attr_in(attr_in), .pnum_in(pnum_in), .done(done),
        .busy(busy), .neg(neg), .rsp_ref(rsp_ref), .rsp_axis(rsp_axis), .rsp_value(rsp_value));
    aprs_checker aprs_checker_i (.clk(clk), .rst_n(rst_n), .req_valid(link_if.req_valid),
        .req_ready(link_if.req_ready), .req_write(link_if.req_write),
        .req_index(link_if.req_index), .req_len(link_if.req_len),
        .wr_valid(link_if.wr_valid), .wr_ready(link_if.wr_ready), .wr_last(link_if.wr_last),
        .rd_valid(link_if.rd_valid), .rd_ready(link_if.rd_ready), .rd_data(link_if.rd_data),
        .rd_last(link_if.rd_last), .rd_error(link_if.rd_error));
    // Clock, 50 ns period
    always #25 clk = ~clk;
    // Capture bytes taken on the link
    always @(posedge clk) begin
        if (link_if.rd_valid && link_if.rd_ready) q1.push_back(link_if.rd_data);
        if (link_if.wr_valid && link_if.wr_ready) w1.push_back(link_if.wr_data);
    end
    // Downstream drive: answers slowly, then scrambles its value lines
    always @(negedge clk) begin
        if (drv_req === 1'h1) begin
            drv_hits = drv_hits + 1;
            d_axis = drv_axis;
            d_svc = drv_svc;
            d_pnum = drv_pnum;
            repeat (12) @(negedge clk);
            drv_value = 32'h311C7289;
            drv_done = 1'h1;
            drv_err = drv_fail;
            @(negedge clk);
            drv_done = 1'h0;
            drv_err = 1'h0;
            drv_value = 32'hCEE38D76;
        end
    end
    // ========================================================================
    // Comparison helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Compare a captured byte stream with its expected image
    task automatic chk_q(input string nm, input logic [7:0] got[$], input logic [7:0] exp[$]);
        chk(nm, got.size(), exp.size());
        foreach (exp[i]) chk(nm, got[i], exp[i]);
    endtask
    // Build the expected response image; v holds the value or the error code
    function automatic void rsp_img(input logic [7:0] r, input logic [7:0] a, input logic ng,
                                    input logic [31:0] v, output logic [7:0] e[$]);
        if (ng) e = {r, aprs_pkg::RSP_KIND_NEG, a, 8'h01, aprs_pkg::FMT_ERROR, 8'h01,
                     v[15:8], v[7:0]};
        else e = {r, aprs_pkg::RSP_KIND_POS, a, 8'h01, aprs_pkg::FMT_DWORD, 8'h01,
                  v[31:24], v[23:16], v[15:8], v[7:0]};
    endfunction
    // Run one parameter read through the controller and judge wire and user side
    task automatic run_ctrl(input logic [7:0] r, input logic [7:0] a, input logic [7:0] at,
                            input logic [15:0] p, input logic ng, input logic [31:0] v);
        logic [7:0] e[$];
        int         n;
        @(negedge clk);
        q1 = {};
        w1 = {};
        drv_hits = 0;
        ref_in = r;
        axis_in = a;
        attr_in = at;
        pnum_in = p;
        start = 1'h1;
        @(negedge clk);
        start = 1'h0;
        chk("busy", busy, 1'h1);
        for (n = 0; n < 400 && done !== 1'h1; n++) @(negedge clk);
        chk("done", done, 1'h1);
        chk("neg", neg, ng);
        chk("rsp_ref", rsp_ref, r);
        chk("rsp_axis", rsp_axis, a);
        if (!ng) chk("rsp_value", rsp_value, v);
        chk("drv_hits", drv_hits, (a != 8'h00));
        rsp_img(r, a, ng, v, e);
        chk_q("rd_bytes", q1, e);
        e = {r, aprs_pkg::REQ_KIND_VENDOR, a, 8'h01, at, aprs_pkg::ELEM_DIRECT, p[15:8], p[7:0],
             8'h00, 8'h00};
        chk_q("wr_bytes", w1, e);
        @(negedge clk);
        chk("busy_end", busy, 1'h0);
    endtask
    // ========================================================================
    // Scenarios
    task automatic t_own();
        run_ctrl(8'h01, 8'h00, 8'h17, 16'h0005, 1'h0, 32'h00000005);
    endtask
    // Own parameter outside the store answers negatively
    task automatic t_own_err();
        run_ctrl(8'hA5, 8'h00, 8'h10, 16'h0020, 1'h1, {16'h0000, aprs_pkg::ERR_ACCESS});
    endtask
    // Unsupported service code in the attribute
    task automatic t_svc();
        run_ctrl(8'h3C, 8'h00, 8'h20, 16'h0001, 1'h1, {16'h0000, aprs_pkg::ERR_BAD_SVC});
    endtask
    // Drive selected by axis, slow answer held off, high word first
    task automatic t_drive();
        run_ctrl(8'hFF, 8'h03, 8'h10, 16'h206C, 1'h0, 32'h311C7289);
        chk("drv_axis", d_axis, 8'h03);
        chk("drv_svc", d_svc, aprs_pkg::SVC_READ);
        chk("drv_pnum", d_pnum, 16'h206C);
    endtask
    // Drive reports a failed access, answered negatively
    task automatic t_drive_err();
        drv_fail = 1'h1;
        run_ctrl(8'h5A, 8'h02, 8'h10, 16'h2129, 1'h1, {16'h0000, aprs_pkg::ERR_ACCESS});
        drv_fail = 1'h0;
    endtask
    // Print counts and the verdict, then stop
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Reset for three cycles, then run every scenario back to back
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
        t_own();
        t_own_err();
        t_svc();
        t_drive();
        t_drive_err();
        t_own();
        wrap_up();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        wrap_up();
    end
endmodule
`default_nettype wire
